// ---- hdl/qmc_pkg.sv ----
/*
  Shared constants and types of the switch QoS / MII global configuration block.
  Assumes a 100 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package qmc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] QMC_IDX_RESERVE = 6'h04;
  localparam logic [5:0] QMC_IDX_QOS = 6'h05;
  localparam logic [5:0] QMC_IDX_MII = 6'h06;
  localparam logic [5:0] QMC_IDX_STORM_LO = 6'h07;
  // Field positions
  localparam int QMC_RESERVE_BIT = 0;
  localparam int QMC_SCHEME_LSB = 2;
  localparam int QMC_SNIFF_BIT = 0;
  localparam int QMC_BP_BIT = 7;
  localparam int QMC_HALF_BIT = 6;
  localparam int QMC_FC_BIT = 5;
  localparam int QMC_TEN_BIT = 4;
  localparam int QMC_NULLVID_BIT = 3;
  // Reset values
  localparam logic [7:0] QMC_STORM_LO_RST = 8'h4A;
  localparam logic [2:0] QMC_STORM_HI_RST = 3'h0;
  localparam logic [1:0] QMC_SCHEME_RST = 2'h0;
  // Buffers reserved per output queue for high priority
  localparam logic [5:0] QMC_HI_RESERVE_BUFS = 6'h30;
  // High-to-low service ratios per scheme code
  localparam logic [3:0] QMC_RATIO_01 = 4'hA;
  localparam logic [3:0] QMC_RATIO_10 = 4'h5;
  localparam logic [3:0] QMC_RATIO_11 = 4'h2;
  // Storm measurement periods
  localparam longint QMC_CLK_HZ = 100000000;
  localparam longint QMC_PERIOD_100M_MS = 50;
  localparam longint QMC_PERIOD_10M_MS = 500;
  localparam int QMC_PERIOD_100M_CYC = int'(QMC_PERIOD_100M_MS * QMC_CLK_HZ / 1000);
  localparam int QMC_PERIOD_10M_CYC = int'(QMC_PERIOD_10M_MS * QMC_CLK_HZ / 1000);
  localparam int QMC_PERIOD_W = 26;
  localparam int QMC_PORTS = 5;
  localparam logic [1:0] QMC_STRAP_WAIT = 2'h3;

  typedef struct packed {
    logic reserve;
    logic [1:0] scheme;
    logic sniff_and;
    logic back_pressure;
    logic half_duplex;
    logic flow_ctl;
    logic ten_mbps;
    logic null_vid_repl;
    logic [10:0] storm_limit;
  } qmc_cfg_t;

  typedef enum logic [0:0] {QMC_BUS_IDLE, QMC_BUS_ANSWER} qmc_bus_state_t;
endpackage : qmc_pkg

// ---- hdl/qmc_storm_port.sv ----
/*
  One input port's broadcast storm limiter: period timer and block counter.
  Assumes one pulse per 64-byte block of broadcast data from the receive MAC.
*/
`timescale 1ns/1ps
module qmc_storm_port #(
  parameter int PERIOD_100M = qmc_pkg::QMC_PERIOD_100M_CYC,
  parameter int PERIOD_10M = qmc_pkg::QMC_PERIOD_10M_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Port traffic
  input wire logic block_in,
  input wire logic ten_mbps_in,
  input wire logic [10:0] limit_in,
  // Discard decision and period end
  output logic drop_out,
  output logic period_end_out
);
  import qmc_pkg::*;

  logic [QMC_PERIOD_W-1:0] period_r;
  logic [10:0] blocks_r;
  logic [QMC_PERIOD_W-1:0] period_last;

  assign period_last = ten_mbps_in ? QMC_PERIOD_W'(PERIOD_10M - 1)
                                   : QMC_PERIOD_W'(PERIOD_100M - 1);
  assign period_end_out = (period_r >= period_last);

  ////////////////////////////////////////////////////////////////////////////
  // period by speed
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      period_r <= '0;
    end else if (period_end_out) begin
      period_r <= '0;
    end else begin
      period_r <= period_r + QMC_PERIOD_W'(1);
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      blocks_r <= '0;
    end else if (period_end_out) begin
      blocks_r <= '0;
    end else if (block_in && blocks_r != 11'h7FF) begin
      blocks_r <= blocks_r + 11'h001;
    end
  end

  assign drop_out = (blocks_r >= limit_in);

  ////////////////////////////////////////////////////////////////////////////
  property p_period_bound;
    @(posedge mclk_in) disable iff (reset_in)
      period_r <= period_last || $past(ten_mbps_in) != ten_mbps_in;
  endproperty
  a_period_bound: assert property (p_period_bound) else $error("period overrun");

  property p_restart;
    @(posedge mclk_in) disable iff (reset_in)
      period_end_out |=> blocks_r == 11'h000 && period_r == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("period did not restart");
endmodule : qmc_storm_port

// ---- hdl/qmc_config.sv ----
/*
  Global QoS, sniff, switch-side MII and storm-limit configuration registers,
  with the logic those settings steer.
  Assumes an Avalon-MM master, strap pins stable around reset, and per-port
  64-byte broadcast block pulses from the receive MACs.
*/
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module qmc_config #(
  parameter int PERIOD_100M = qmc_pkg::QMC_PERIOD_100M_CYC,
  parameter int PERIOD_10M = qmc_pkg::QMC_PERIOD_10M_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Strap pins
  input wire logic duplex_strap_pin_in,
  input wire logic flow_ctl_strap_pin_in,
  input wire logic speed_strap_pin_in,
  // Configuration view
  output qmc_pkg::qmc_cfg_t cfg_out,
  output logic [5:0] hi_reserved_bufs_out,
  // Egress scheduler
  input wire logic sched_req_in,
  input wire logic hi_pending_in,
  input wire logic lo_pending_in,
  output logic grant_hi_out,
  output logic grant_lo_out,
  // Sniffer
  input wire logic pkt_valid_in,
  input wire logic sniff_src_match_in,
  input wire logic sniff_dst_match_in,
  output logic mirror_out,
  // Null identifier replacement
  input wire logic vid_valid_in,
  input wire logic [11:0] vlan_identifier_in,
  input wire logic [11:0] port_vlan_identifier_in,
  output logic vid_valid_out,
  output logic [11:0] vlan_identifier_out,
  // Broadcast storm
  input wire logic [4:0] bcast_block_in,
  input wire logic [4:0] port_ten_mbps_in,
  output logic [4:0] storm_drop_out
);
  import qmc_pkg::*;

  qmc_bus_state_t bus_state_r;
  logic [31:0] readdata_r;
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;
  logic [2:0] strap_s3_r;
  logic [1:0] strap_wait_r;
  logic straps_loaded_r;
  logic strap_load;
  logic [5:0] idx;
  logic wr_lo;
  logic reserve_r;
  logic [1:0] scheme_r;
  logic sniff_and_r;
  logic [7:0] mii_r;
  logic [7:0] storm_lo_r;
  logic [3:0] ratio;
  logic [3:0] hi_run_r;
  logic grant_hi_r;
  logic grant_lo_r;
  logic mirror_r;
  logic vid_valid_r;
  logic [11:0] vid_r;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      strap_s3_r <= 3'h0;
    end else begin
      strap_s1_r <= {duplex_strap_pin_in, flow_ctl_strap_pin_in, speed_strap_pin_in};
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      strap_wait_r <= 2'h0;
      straps_loaded_r <= 1'b0;
    end else if (!straps_loaded_r) begin
      if (strap_wait_r != QMC_STRAP_WAIT) begin
        strap_wait_r <= strap_wait_r + 2'h1;
      end else if (strap_s2_r == strap_s3_r) begin
        straps_loaded_r <= 1'b1;
      end
    end
  end

  assign strap_load = !straps_loaded_r && strap_wait_r == QMC_STRAP_WAIT
                      && strap_s2_r == strap_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait state
  assign idx = avs_address_in[7:2];
  assign avs_waitrequest_out = (avs_read_in || avs_write_in)
                               && (bus_state_r != QMC_BUS_ANSWER);
  assign avs_readdata_out = readdata_r;
  assign wr_lo = bus_state_r == QMC_BUS_ANSWER && avs_write_in && avs_byteenable_in[0];

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      bus_state_r <= QMC_BUS_IDLE;
    end else begin
      case (bus_state_r)
        QMC_BUS_IDLE: begin
          if ((avs_read_in || avs_write_in) && straps_loaded_r) begin
            bus_state_r <= QMC_BUS_ANSWER;
          end
        end
        QMC_BUS_ANSWER: begin
          bus_state_r <= QMC_BUS_IDLE;
        end
        default: begin
          bus_state_r <= QMC_BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      QMC_IDX_RESERVE: rd_mux[QMC_RESERVE_BIT] = reserve_r;
      QMC_IDX_QOS: begin
        rd_mux[QMC_SCHEME_LSB +: 2] = scheme_r;
        rd_mux[QMC_SNIFF_BIT] = sniff_and_r;
      end
      QMC_IDX_MII: rd_mux[7:0] = mii_r;
      QMC_IDX_STORM_LO: rd_mux[7:0] = storm_lo_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      readdata_r <= 32'h0000_0000;
    end else if (bus_state_r == QMC_BUS_IDLE && avs_read_in) begin
      readdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reserve bit store
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      reserve_r <= 1'b0;
    end else if (wr_lo && idx == QMC_IDX_RESERVE) begin
      reserve_r <= avs_writedata_in[QMC_RESERVE_BIT];
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      scheme_r <= QMC_SCHEME_RST;
      sniff_and_r <= 1'b0;
    end else if (wr_lo && idx == QMC_IDX_QOS) begin
      scheme_r <= avs_writedata_in[QMC_SCHEME_LSB +: 2];
      sniff_and_r <= avs_writedata_in[QMC_SNIFF_BIT];
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      mii_r <= {5'h00, QMC_STORM_HI_RST};
    end else if (strap_load) begin
      mii_r[QMC_HALF_BIT] <= strap_s3_r[2];
      mii_r[QMC_FC_BIT] <= strap_s3_r[1];
      mii_r[QMC_TEN_BIT] <= strap_s3_r[0];
    end else if (wr_lo && idx == QMC_IDX_MII) begin
      mii_r <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      storm_lo_r <= QMC_STORM_LO_RST;
    end else if (wr_lo && idx == QMC_IDX_STORM_LO) begin
      storm_lo_r <= avs_writedata_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs
  always_comb begin
    cfg_out.reserve = reserve_r;
    cfg_out.scheme = scheme_r;
    cfg_out.sniff_and = sniff_and_r;
    cfg_out.back_pressure = mii_r[QMC_BP_BIT];
    cfg_out.half_duplex = mii_r[QMC_HALF_BIT];
    cfg_out.flow_ctl = mii_r[QMC_FC_BIT];
    cfg_out.ten_mbps = mii_r[QMC_TEN_BIT];
    cfg_out.null_vid_repl = mii_r[QMC_NULLVID_BIT];
    cfg_out.storm_limit = {mii_r[2:0], storm_lo_r};
  end

  assign hi_reserved_bufs_out = reserve_r ? QMC_HI_RESERVE_BUFS : 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // ratio scheduler
  always_comb begin
    case (scheme_r)
      2'h1: ratio = QMC_RATIO_01;
      2'h2: ratio = QMC_RATIO_10;
      2'h3: ratio = QMC_RATIO_11;
      default: ratio = 4'h0;
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      grant_hi_r <= 1'b0;
      grant_lo_r <= 1'b0;
      hi_run_r <= 4'h0;
    end else begin
      grant_hi_r <= 1'b0;
      grant_lo_r <= 1'b0;
      if (sched_req_in) begin
        if (hi_pending_in && !(lo_pending_in && ratio != 4'h0 && hi_run_r >= ratio)) begin
          grant_hi_r <= 1'b1;
          if (hi_run_r != 4'hF) begin
            hi_run_r <= hi_run_r + 4'h1;
          end
        end else if (lo_pending_in) begin
          grant_lo_r <= 1'b1;
          hi_run_r <= 4'h0;
        end
      end
    end
  end

  assign grant_hi_out = grant_hi_r;
  assign grant_lo_out = grant_lo_r;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      mirror_r <= 1'b0;
    end else begin
      mirror_r <= pkt_valid_in && (sniff_and_r ? (sniff_src_match_in && sniff_dst_match_in)
                                               : (sniff_src_match_in || sniff_dst_match_in));
    end
  end

  assign mirror_out = mirror_r;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      vid_valid_r <= 1'b0;
      vid_r <= 12'h000;
    end else begin
      vid_valid_r <= vid_valid_in;
      if (vid_valid_in) begin
        vid_r <= (mii_r[QMC_NULLVID_BIT] && vlan_identifier_in == 12'h000)
                 ? port_vlan_identifier_in : vlan_identifier_in;
      end
    end
  end

  assign vid_valid_out = vid_valid_r;
  assign vlan_identifier_out = vid_r;

  ////////////////////////////////////////////////////////////////////////////
  // per-port storm limiters
  for (genvar p = 0; p < QMC_PORTS; p++) begin : g_storm
    qmc_storm_port #(
      .PERIOD_100M(PERIOD_100M),
      .PERIOD_10M(PERIOD_10M)
    ) u_port (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .block_in(bcast_block_in[p]),
      .ten_mbps_in(port_ten_mbps_in[p]),
      .limit_in(cfg_out.storm_limit),
      .drop_out(storm_drop_out[p]),
      .period_end_out()
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_reserve;
    @(posedge mclk_in) disable iff (reset_in)
      hi_reserved_bufs_out == (reserve_r ? 6'h30 : 6'h00);
  endproperty
  a_reserve: assert property (p_reserve) else $error("reserved count wrong");

  property p_scheme_strict;
    @(posedge mclk_in) disable iff (reset_in)
      scheme_r == 2'h0 && sched_req_in && hi_pending_in |=> grant_hi_r && !grant_lo_r;
  endproperty
  a_scheme_strict: assert property (p_scheme_strict) else $error("strict priority lost");

  property p_ratio_run;
    @(posedge mclk_in) disable iff (reset_in)
      scheme_r != 2'h0 && sched_req_in && lo_pending_in && hi_run_r >= ratio
        |=> grant_lo_r;
  endproperty
  a_ratio_run: assert property (p_ratio_run) else $error("low queue starved");

  property p_sniff_and;
    @(posedge mclk_in) disable iff (reset_in)
      sniff_and_r && pkt_valid_in && !(sniff_src_match_in && sniff_dst_match_in)
        |=> !mirror_r;
  endproperty
  a_sniff_and: assert property (p_sniff_and) else $error("and-mode mirrored");

  property p_sniff_or;
    @(posedge mclk_in) disable iff (reset_in)
      !sniff_and_r && pkt_valid_in && (sniff_src_match_in || sniff_dst_match_in)
        |=> mirror_r;
  endproperty
  a_sniff_or: assert property (p_sniff_or) else $error("or-mode missed");

  property p_mii_write;
    @(posedge mclk_in) disable iff (reset_in)
      wr_lo && idx == QMC_IDX_MII && straps_loaded_r
        |=> cfg_out.back_pressure == $past(avs_writedata_in[7])
            && cfg_out.half_duplex == $past(avs_writedata_in[6]);
  endproperty
  a_mii_write: assert property (p_mii_write) else $error("mii bits not stored");

  property p_strap;
    @(posedge mclk_in) disable iff (reset_in)
      strap_load |=> cfg_out.half_duplex == $past(strap_s3_r[2])
                     && cfg_out.flow_ctl == $past(strap_s3_r[1])
                     && cfg_out.ten_mbps == $past(strap_s3_r[0]);
  endproperty
  a_strap: assert property (p_strap) else $error("strap default wrong");

  property p_null_vid;
    @(posedge mclk_in) disable iff (reset_in)
      vid_valid_in && mii_r[QMC_NULLVID_BIT] && vlan_identifier_in == 12'h000
        |=> vlan_identifier_out == $past(port_vlan_identifier_in);
  endproperty
  a_null_vid: assert property (p_null_vid) else $error("null id not replaced");

  property p_limit;
    @(posedge mclk_in) disable iff (reset_in)
      cfg_out.storm_limit == {mii_r[2:0], storm_lo_r} && $rose(straps_loaded_r)
        |-> cfg_out.storm_limit[7:0] == 8'h4A || $past(wr_lo);
  endproperty
  a_limit: assert property (p_limit) else $error("storm limit reset wrong");

  c_read: cover property (@(posedge mclk_in) disable iff (reset_in)
    avs_read_in && !avs_waitrequest_out);
  c_ratio: cover property (@(posedge mclk_in) disable iff (reset_in)
    scheme_r == 2'h3 && grant_lo_r);
  c_mirror: cover property (@(posedge mclk_in) disable iff (reset_in) mirror_r);
  c_drop: cover property (@(posedge mclk_in) disable iff (reset_in) |storm_drop_out);
endmodule : qmc_config

// ---- verif/qmc_config_test.sv ----
/*
  Self-checking bench for the QoS / MII / storm configuration block.
  Assumes the block answers on Avalon-MM and short storm periods by parameter.
*/
`timescale 1ns/1ps
module qmc_config_test;
  import qmc_pkg::*;
  localparam int PER_FAST = 20;
  localparam int PER_SLOW = 200;
  localparam int LIMIT = 30000;
  logic mclk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [7:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0] avs_byteenable_in;
  logic duplex_strap_pin_in, flow_ctl_strap_pin_in, speed_strap_pin_in;
  qmc_cfg_t cfg_out;
  logic [5:0] hi_reserved_bufs_out;
  logic sched_req_in, hi_pending_in, lo_pending_in, grant_hi_out, grant_lo_out;
  logic pkt_valid_in, sniff_src_match_in, sniff_dst_match_in, mirror_out;
  logic vid_valid_in, vid_valid_out;
  logic [11:0] vlan_identifier_in, port_vlan_identifier_in, vlan_identifier_out;
  logic [4:0] bcast_block_in, port_ten_mbps_in, storm_drop_out;
  logic [7:0] sh_res, sh_qos, sh_mii, sh_lo;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  qmc_config #(.PERIOD_100M(PER_FAST), .PERIOD_10M(PER_SLOW)) qmc_config_i (
    .mclk_in(mclk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .duplex_strap_pin_in(duplex_strap_pin_in), .flow_ctl_strap_pin_in(flow_ctl_strap_pin_in),
    .speed_strap_pin_in(speed_strap_pin_in), .cfg_out(cfg_out),
    .hi_reserved_bufs_out(hi_reserved_bufs_out), .sched_req_in(sched_req_in),
    .hi_pending_in(hi_pending_in), .lo_pending_in(lo_pending_in),
    .grant_hi_out(grant_hi_out), .grant_lo_out(grant_lo_out),
    .pkt_valid_in(pkt_valid_in), .sniff_src_match_in(sniff_src_match_in),
    .sniff_dst_match_in(sniff_dst_match_in), .mirror_out(mirror_out),
    .vid_valid_in(vid_valid_in), .vlan_identifier_in(vlan_identifier_in),
    .port_vlan_identifier_in(port_vlan_identifier_in), .vid_valid_out(vid_valid_out),
    .vlan_identifier_out(vlan_identifier_out), .bcast_block_in(bcast_block_in),
    .port_ten_mbps_in(port_ten_mbps_in), .storm_drop_out(storm_drop_out)
  );

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0, exp}, {31'h0, got});
  endtask : chk_bit

  task automatic test_done(input string n);
    $display("test %s done, checks %0d, mismatches %0d", n, num_checks, err_count);
  endtask : test_done

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  function automatic qmc_cfg_t exp_cfg();
    qmc_cfg_t c;
    c.reserve = sh_res[0];
    c.scheme = sh_qos[3:2];
    c.sniff_and = sh_qos[0];
    c.back_pressure = sh_mii[7];
    c.half_duplex = sh_mii[6];
    c.flow_ctl = sh_mii[5];
    c.ten_mbps = sh_mii[4];
    c.null_vid_repl = sh_mii[3];
    c.storm_limit = {sh_mii[2:0], sh_lo};
    return c;
  endfunction : exp_cfg

  function automatic logic [31:0] exp_rd(input logic [5:0] idx);
    case (idx)
      QMC_IDX_RESERVE: return {24'h0, sh_res};
      QMC_IDX_QOS: return {24'h0, sh_qos};
      QMC_IDX_MII: return {24'h0, sh_mii};
      QMC_IDX_STORM_LO: return {24'h0, sh_lo};
      default: return 32'h0;
    endcase
  endfunction : exp_rd

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
      input logic [3:0] be, output logic [31:0] rd);
    avs_address_in <= {idx, 2'b00};
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    avs_writedata_in <= wd;
    avs_byteenable_in <= be;
    do begin
      @(posedge mclk_in);
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge mclk_in);
  endtask : bus

  task automatic put(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] rd;
    bus(1'b1, idx, {24'($urandom()), d}, be, rd);
    if (be[0]) begin
      case (idx)
        QMC_IDX_RESERVE: sh_res = d & 8'h01;
        QMC_IDX_QOS: sh_qos = d & 8'h0D;
        QMC_IDX_MII: sh_mii = d;
        QMC_IDX_STORM_LO: sh_lo = d;
        default: ;
      endcase
    end
  endtask : put

  task automatic get(input logic [5:0] idx);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, 4'hF, rd);
    chk_word("readdata", exp_rd(idx), rd);
    chk_word("cfg", {12'h0, exp_cfg()}, {12'h0, cfg_out});
    chk_word("hi_bufs", sh_res[0] ? 32'h30 : 32'h0, {26'h0, hi_reserved_bufs_out});
  endtask : get

  task automatic reset_check(input logic [2:0] st);
    reset_in <= 1'b1;
    {duplex_strap_pin_in, flow_ctl_strap_pin_in, speed_strap_pin_in} <= st;
    repeat (6) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    sh_res = 8'h00;
    sh_qos = 8'h00;
    sh_mii = {1'b0, st, 4'h0};
    sh_lo = 8'h4A;
    for (int i = 0; i < 5; i++) begin
      get(6'(QMC_IDX_RESERVE + i));
    end
    test_done("reset");
  endtask : reset_check

  task automatic wait_drop(input int p, input logic lvl, input int mx, output int n);
    n = 0;
    while (storm_drop_out[p] !== lvl && n < mx) begin
      @(negedge mclk_in);
      n++;
    end
    @(posedge mclk_in);
  endtask : wait_drop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] st;
    logic [5:0] idxs [6];
    logic [11:0] v;
    int n, hi_run, lo_cnt, per;
    bit seen;
    void'($urandom(33));
    idxs = '{QMC_IDX_RESERVE, QMC_IDX_QOS, QMC_IDX_MII, QMC_IDX_STORM_LO, 6'h20, 6'h03};
    reset_in = 1'b1;
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, avs_byteenable_in} = '0;
    {sched_req_in, hi_pending_in, lo_pending_in, pkt_valid_in} = '0;
    {sniff_src_match_in, sniff_dst_match_in, vid_valid_in} = '0;
    {vlan_identifier_in, port_vlan_identifier_in, bcast_block_in, port_ten_mbps_in} = '0;
    {duplex_strap_pin_in, flow_ctl_strap_pin_in, speed_strap_pin_in} = '0;
    st = 3'($urandom());
    reset_check(st);
    put(QMC_IDX_RESERVE, 8'hFF, 4'hF);
    get(QMC_IDX_RESERVE);
    for (int i = 0; i < 16; i++) begin
      n = $urandom_range(5, 0);
      put(idxs[n], 8'($urandom()), ($urandom_range(3, 0) == 0) ? 4'hE : 4'hF);
      get(idxs[n]);
    end
    test_done("registers");
    for (int m = 0; m < 2; m++) begin
      put(QMC_IDX_QOS, {7'h0, 1'(m)}, 4'hF);
      put(QMC_IDX_MII, {4'h0, 1'(m), 3'h0}, 4'hF);
      for (int sd = 0; sd < 4; sd++) begin
        v = sd[0] ? 12'($urandom()) : 12'h000;
        pkt_valid_in <= 1'b1;
        {sniff_src_match_in, sniff_dst_match_in} <= 2'(sd);
        vid_valid_in <= 1'b1;
        vlan_identifier_in <= v;
        port_vlan_identifier_in <= 12'($urandom());
        @(posedge mclk_in);
        pkt_valid_in <= 1'b0;
        vid_valid_in <= 1'b0;
        @(negedge mclk_in);
        chk_bit("mirror", m ? (sd == 3) : (sd != 0), mirror_out);
        chk_bit("vid_valid", 1'b1, vid_valid_out);
        chk_word("vid", {20'h0, (m && v == 0) ? port_vlan_identifier_in : v},
          {20'h0, vlan_identifier_out});
        @(posedge mclk_in);
      end
    end
    test_done("sniff_vid");
    put(QMC_IDX_RESERVE, 8'h01, 4'hF);
    for (int s = 0; s < 4; s++) begin
      put(QMC_IDX_QOS, {4'h0, 2'(s), 2'h0}, 4'hF);
      {sched_req_in, hi_pending_in, lo_pending_in} <= 3'b111;
      hi_run = 0;
      lo_cnt = 0;
      seen = 0;
      repeat (48) begin
        @(negedge mclk_in);
        if (grant_hi_out === 1'b1) hi_run++;
        if (grant_lo_out === 1'b1) begin
          lo_cnt++;
          if (seen) chk_word("ratio", (s == 1) ? 10 : (s == 2) ? 5 : 2, hi_run);
          seen = 1;
          hi_run = 0;
        end
      end
      @(posedge mclk_in);
      {sched_req_in, hi_pending_in, lo_pending_in} <= 3'b000;
      chk_bit("lo_grants", s != 0, lo_cnt >= 2);
    end
    test_done("scheduler");
    put(QMC_IDX_MII, 8'h00, 4'hF);
    put(QMC_IDX_STORM_LO, 8'h01, 4'hF);
    get(QMC_IDX_STORM_LO);
    port_ten_mbps_in <= 5'b00010;
    for (int p = 0; p < 2; p++) begin
      per = p ? PER_SLOW : PER_FAST;
      repeat (2) begin
        bcast_block_in <= 5'(1 << p);
        repeat (2) @(posedge mclk_in);
        bcast_block_in <= 5'h00;
        wait_drop(p, 1'b1, 4, n);
        chk_bit("drop", 1'b1, storm_drop_out[p]);
        chk_bit("other", 1'b0, storm_drop_out[1 - p]);
        wait_drop(p, 1'b0, per + 4, n);
      end
      chk_bit("period", 1'b1, n >= per - 6 && n <= per);
    end
    test_done("storm");
    reset_check(~st);
    tally_and_finish();
  end
endmodule : qmc_config_test
